// ===== shared/lts_pkg.sv
`default_nettype none
// =============================================================================
// Shared constants and carriers of the latch timestamp capture block.
// =============================================================================
package lts_pkg;

    // =========================================================================
    // Register byte offsets, as seen by both readers.
    // =========================================================================
    localparam logic [11:0] LTS_L0_RISE_OFS = 12'h09B0; // Capture input zero, rising edge.
    localparam logic [11:0] LTS_L0_FALL_OFS = 12'h09B8; // Capture input zero, falling edge.
    localparam logic [11:0] LTS_L1_RISE_OFS = 12'h09C0; // Capture input one, rising edge.
    localparam logic [11:0] LTS_L1_FALL_OFS = 12'h09C8; // Capture input one, falling edge.
    localparam logic [11:0] LTS_FRAME_OFS = 12'h09F0; // Frame event time.
    localparam logic [11:0] LTS_HI_WORD_OFS = 12'h0004; // Upper word of a 64-bit register.

    // =========================================================================
    // Field positions and reset values.
    // =========================================================================
    localparam int LTS_FREEZE_LSB = 8; // Lowest bit that is frozen by a low-byte read.
    localparam logic [63:0] LTS_TS_RESET = 64'h0000_0000_0000_0000; // Timestamp reset value.
    localparam logic [31:0] LTS_FRAME_RESET = 32'h0000_0000; // Frame event time reset value.

    // =========================================================================
    // Carriers.
    // =========================================================================
    // One register access request from a reader; addr is a byte address.
    typedef struct packed {
        logic req;
        logic wr;
        logic [11:0] addr;
    } lts_bus_req_t;

    // One read answer.
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } lts_bus_rsp_t;

    // Per-input configuration: owner of the flags and capture mode per edge.
    typedef struct packed {
        logic host_assign;
        logic [1:0] single_mode;
    } lts_cap_cfg_t;

    // Per-input status: pin level and the two sticky edge flags.
    typedef struct packed {
        logic pin_level;
        logic fall_seen;
        logic rise_seen;
    } lts_cap_stat_t;

endpackage
`default_nettype wire

// ===== design/lts_edge_capture.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// One capture input: synchroniser, edge detection, timestamps and flags.
// =============================================================================
module lts_edge_capture #(
    parameter int TIME_W = 64 // Width of the system time.
) (
    input wire logic clk_sys, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable, freezes all state while low.
    input wire logic pin_async, // Capture pin, asynchronous to clk_sys.
    input wire logic [TIME_W-1:0] sys_time, // Running system time.
    input wire logic [1:0] single_mode, // Per edge: 1 single event, 0 continuous.
    input wire logic [1:0] clr, // Per edge flag clear pulse.
    output logic [TIME_W-1:0] rise_ts, // Rising edge timestamp.
    output logic [TIME_W-1:0] fall_ts, // Falling edge timestamp.
    output logic [1:0] edge_pulse, // Edge detected this cycle, bit 0 rising.
    output var lts_pkg::lts_cap_stat_t stat // Pin level and edge flags.
);
    import lts_pkg::*;

    // The capture logic needs room above the low byte, which is never frozen.
    if (TIME_W <= LTS_FREEZE_LSB || TIME_W > 64)
    begin : g_bad_width
        $error("lts_edge_capture: unsupported TIME_W");
    end

    logic sync_meta; // First synchroniser stage, read only by the second.
    logic sync_lvl; // Synchronised pin level.
    logic prev_lvl; // Level one cycle earlier.
    logic [2:0] fill; // Marks the pipeline as holding real pin samples.
    logic [1:0] seen; // Sticky edge flags, bit 0 rising.
    logic [1:0] take; // Edge that is allowed to overwrite its timestamp.
    logic [1:0] next_seen; // Next flag value.

    // Edges are only believed once the pipeline is filled, so reset is no edge.
    assign edge_pulse = {fill[2] & ~sync_lvl & prev_lvl, fill[2] & sync_lvl & ~prev_lvl};
    // Continuous edges always capture; a single event edge only while its flag is clear.
    assign take = edge_pulse & (~single_mode | ~seen);
    // A flag exists only in single event mode, and a new edge beats a clear.
    assign next_seen = single_mode & ((seen & ~clr) | edge_pulse);
    assign stat = '{pin_level: sync_lvl, fall_seen: seen[1], rise_seen: seen[0]};

    // =========================================================================
    // Two-stage synchroniser and edge history.
    // =========================================================================
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_meta <= 1'b0;
            sync_lvl <= 1'b0;
            prev_lvl <= 1'b0;
            fill <= 3'h0;
        end
        else if (ce)
        begin
            sync_meta <= pin_async;
            sync_lvl <= sync_meta;
            prev_lvl <= sync_lvl;
            fill <= {fill[1:0], 1'b1};
        end
    end

    // =========================================================================
    // Sticky flags.
    // =========================================================================
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            seen <= 2'h0;
        end
        else if (ce)
        begin
            seen <= next_seen;
        end
    end

    // =========================================================================
    // Timestamp capture of the system time.
    // =========================================================================
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rise_ts <= LTS_TS_RESET[TIME_W-1:0];
            fall_ts <= LTS_TS_RESET[TIME_W-1:0];
        end
        else if (ce)
        begin
            if (take[0])
            begin
                rise_ts <= sys_time;
            end
            if (take[1])
            begin
                fall_ts <= sys_time;
            end
        end
    end

    // =========================================================================
    // Checks.
    // =========================================================================
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    rise_capture_a: assert property (
        ce && edge_pulse[0] && (!single_mode[0] || !seen[0]) |=> rise_ts == $past(sys_time))
        else $error("rising edge did not capture time");
    fall_capture_a: assert property (
        ce && edge_pulse[1] && (!single_mode[1] || !seen[1]) |=> fall_ts == $past(sys_time))
        else $error("falling edge did not capture time");
    single_hold_a: assert property (
        ce && single_mode[0] && seen[0] && !clr[0] |=> $stable(rise_ts) && stat.rise_seen)
        else $error("single event timestamp overwritten");
    cont_flag_zero_a: assert property (
        ce && !single_mode[1] |=> !stat.fall_seen)
        else $error("flag set in continuous mode");
    single_cover_c: cover property (
        ce && single_mode[0] && edge_pulse[0] ##[1:20] ce && edge_pulse[0] && seen[0]);

endmodule
`default_nettype wire

// ===== design/lts_capture_top.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// Timestamp capture unit with two independent readers.
// =============================================================================
module lts_capture_top (
    input wire logic clk_sys, // System clock, 50 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable, freezes all state while low.
    input wire logic capture_input_zero, // Capture pin zero, asynchronous.
    input wire logic capture_input_one, // Capture pin one, asynchronous.
    input wire logic [63:0] sys_time, // Running system time.
    input wire logic [31:0] local_time, // Running local time.
    input wire logic frame_start, // Pulse at the start of a received frame.
    input wire logic buffer_channel_manager_event, // Pulse: a network-side event is raised.
    input wire lts_pkg::lts_cap_cfg_t cap0_cfg, // Configuration of input zero.
    input wire lts_pkg::lts_cap_cfg_t cap1_cfg, // Configuration of input one.
    input wire logic host_wr_ack_en, // Host clears flags by writes instead of reads.
    input wire lts_pkg::lts_bus_req_t net_req, // Network-side access request.
    output var lts_pkg::lts_bus_rsp_t net_rsp, // Network-side read answer.
    input wire lts_pkg::lts_bus_req_t host_req, // Local host interface request.
    output var lts_pkg::lts_bus_rsp_t host_rsp, // Local host interface read answer.
    output var lts_pkg::lts_cap_stat_t cap0_stat, // Status of input zero.
    output var lts_pkg::lts_cap_stat_t cap1_stat // Status of input one.
);
    import lts_pkg::*;

    // =========================================================================
    // Address decode.
    // =========================================================================
    // Returns {hit, upper word, register index}; index 4 is the frame time.
    function automatic logic [4:0] lts_decode(input logic [11:0] a);
        logic [4:0] d;
        d = 5'h00;
        if (a == LTS_L0_RISE_OFS)
            d = 5'h10;
        else if (a == LTS_L0_RISE_OFS + LTS_HI_WORD_OFS)
            d = 5'h18;
        else if (a == LTS_L0_FALL_OFS)
            d = 5'h11;
        else if (a == LTS_L0_FALL_OFS + LTS_HI_WORD_OFS)
            d = 5'h19;
        else if (a == LTS_L1_RISE_OFS)
            d = 5'h12;
        else if (a == LTS_L1_RISE_OFS + LTS_HI_WORD_OFS)
            d = 5'h1A;
        else if (a == LTS_L1_FALL_OFS)
            d = 5'h13;
        else if (a == LTS_L1_FALL_OFS + LTS_HI_WORD_OFS)
            d = 5'h1B;
        else if (a == LTS_FRAME_OFS)
            d = 5'h14;
        return d;
    endfunction

    // =========================================================================
    // Shared signals.
    // =========================================================================
    logic [63:0] live [5]; // Current value of every register.
    logic [31:0] frame_time; // Frame event time register.
    logic [31:0] frame_pending; // Local time at the start of the current frame.
    lts_cap_cfg_t cfg_a [2]; // Configuration by input.
    lts_cap_stat_t stat_a [2]; // Status by input.
    logic [1:0] edge_a [2]; // Edge pulses by input.
    lts_bus_req_t side_req [2]; // Requests, 0 network, 1 host.
    lts_bus_rsp_t side_rsp [2]; // Answers, 0 network, 1 host.
    logic [3:0] side_clr [2]; // Flag clears raised by each side, by register index.
    logic [3:0] clr_all; // Flag clears from both sides.

    assign cfg_a[0] = cap0_cfg;
    assign cfg_a[1] = cap1_cfg;
    assign cap0_stat = stat_a[0];
    assign cap1_stat = stat_a[1];
    assign side_req[0] = net_req;
    assign side_req[1] = host_req;
    assign net_rsp = side_rsp[0];
    assign host_rsp = side_rsp[1];
    assign clr_all = side_clr[0] | side_clr[1];
    assign live[4] = {32'h0000_0000, frame_time};

    // =========================================================================
    // Capture inputs; register index 2*l is rising, 2*l+1 falling.
    // =========================================================================
    for (genvar l = 0; l < 2; l++)
    begin : g_cap
        lts_edge_capture #(
            .TIME_W(64)
        ) u_cap (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ce(ce),
            .pin_async(l == 0 ? capture_input_zero : capture_input_one),
            .sys_time(sys_time),
            .single_mode(cfg_a[l].single_mode),
            .clr(clr_all[2*l+1:2*l]),
            .rise_ts(live[2*l]),
            .fall_ts(live[2*l+1]),
            .edge_pulse(edge_a[l]),
            .stat(stat_a[l])
        );
    end

    // =========================================================================
    // One reader port per side, each with its own frozen copies.
    // =========================================================================
    for (genvar s = 0; s < 2; s++)
    begin : g_side
        logic [4:0] dec; // Decoded address.
        logic hit; // Address maps to a register word.
        logic hi; // Upper word selected.
        logic [2:0] idx; // Register index.
        logic is_latch; // One of the four timestamp registers.
        logic owner; // The host owns the flags of the addressed input.
        logic low_rd; // Read of the word holding bits 7 to 0.
        logic ack_wr; // Accepted acknowledge write.
        logic clr_hit; // This access clears a flag.
        logic [31:0] next_data; // Answer data.
        logic [55:0] snap [5]; // Frozen bits 63 to 8 of each register.

        assign dec = lts_decode(side_req[s].addr);
        assign hit = dec[4];
        assign hi = dec[3];
        assign idx = dec[2:0];
        assign is_latch = ~idx[2];
        assign owner = cfg_a[idx[1]].host_assign;
        assign low_rd = side_req[s].req & ~side_req[s].wr & hit & ~hi;
        // Only the host may write, only with acknowledge on; network writes do nothing.
        assign ack_wr = (s == 1) & side_req[s].req & side_req[s].wr & hit & is_latch
            & host_wr_ack_en;
        // Network reads clear when the network owns the flags, host reads or writes otherwise.
        assign clr_hit = (s == 0) ? (low_rd & is_latch & ~owner)
            : (owner & ((low_rd & is_latch & ~host_wr_ack_en) | ack_wr));
        assign side_clr[s] = clr_hit ? (4'h1 << idx[1:0]) : 4'h0;
        // The low word is live; the upper word comes from this side's frozen copy.
        assign next_data = !hit ? 32'h0000_0000
            : (hi ? snap[idx][55:24] : live[idx][31:0]);

        // Answer and frozen copies of this side.
        always_ff @(posedge clk_sys or negedge nrst)
        begin
            if (!nrst)
            begin
                side_rsp[s] <= '{valid: 1'b0, data: 32'h0000_0000};
                for (int i = 0; i < 5; i++)
                begin
                    snap[i] <= LTS_TS_RESET[63:LTS_FREEZE_LSB];
                end
            end
            else if (ce)
            begin
                side_rsp[s].valid <= side_req[s].req & ~side_req[s].wr;
                if (side_req[s].req && !side_req[s].wr)
                begin
                    side_rsp[s].data <= next_data;
                end
                if (low_rd)
                begin
                    snap[idx] <= live[idx][63:LTS_FREEZE_LSB];
                end
            end
        end
    end

    // =========================================================================
    // Frame event time: start-of-frame local time, kept on a network event.
    // =========================================================================
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            frame_pending <= LTS_FRAME_RESET;
            frame_time <= LTS_FRAME_RESET;
        end
        else if (ce)
        begin
            if (frame_start)
            begin
                frame_pending <= local_time;
            end
            if (buffer_channel_manager_event)
            begin
                frame_time <= frame_start ? local_time : frame_pending;
            end
        end
    end

    // =========================================================================
    // Checks.
    // =========================================================================
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    net_freeze_a: assert property (
        ce && g_side[0].low_rd && g_side[0].idx == 3'h0
        |=> g_side[0].snap[0] == $past(live[0][63:8]))
        else $error("network copy not frozen");
    host_freeze_a: assert property (
        ce && g_side[1].low_rd && g_side[1].idx == 3'h1 ##1 !g_side[1].low_rd
        ##1 ce && host_req.req && !host_req.wr
        && host_req.addr == LTS_L0_FALL_OFS + LTS_HI_WORD_OFS
        |=> host_rsp.valid && host_rsp.data == $past(live[1][63:32], 3))
        else $error("host upper word not consistent");
    frame_freeze_a: assert property (
        ce && g_side[0].low_rd && g_side[0].idx == 3'h4 |=> net_rsp.data == $past(frame_time)
        && g_side[0].snap[4][23:0] == $past(frame_time[31:8]))
        else $error("frame time read not frozen");
    net_rd_clear_a: assert property (
        ce && net_req.req && !net_req.wr && net_req.addr == LTS_L0_RISE_OFS
        && !cap0_cfg.host_assign && !edge_a[0][0] |=> !cap0_stat.rise_seen)
        else $error("network read left flag set");
    host_rd_clear_a: assert property (
        ce && host_req.req && !host_req.wr && host_req.addr == LTS_L1_RISE_OFS
        && cap1_cfg.host_assign && !host_wr_ack_en && !edge_a[1][0]
        |=> !cap1_stat.rise_seen)
        else $error("host read left flag set");
    host_ack_clear_a: assert property (
        ce && host_req.req && host_req.wr
        && host_req.addr == LTS_L1_FALL_OFS + LTS_HI_WORD_OFS
        && cap1_cfg.host_assign && host_wr_ack_en && !edge_a[1][1]
        |=> !cap1_stat.fall_seen)
        else $error("acknowledge write left flag set");
    net_write_ign_a: assert property (
        ce && net_req.req && net_req.wr && cap1_stat.rise_seen && cap1_cfg.single_mode[0]
        && !(host_req.req && cap1_cfg.host_assign)
        |=> cap1_stat.rise_seen && $stable(live[2]))
        else $error("network write changed timestamp state");
    host_wr_refused_a: assert property (
        ce && host_req.req && host_req.wr && !host_wr_ack_en && cap1_stat.rise_seen
        && cap1_cfg.single_mode[0] && !net_req.req |=> cap1_stat.rise_seen)
        else $error("refused host write cleared flag");
    frame_capture_a: assert property (
        ce && frame_start ##1 ce && buffer_channel_manager_event && !frame_start
        |=> frame_time == $past(local_time, 2))
        else $error("frame event time wrong");

    net_split_read_c: cover property (
        ce && g_side[0].low_rd && g_side[0].idx == 3'h0
        ##[1:8] ce && net_req.req && net_req.addr == LTS_L0_RISE_OFS + LTS_HI_WORD_OFS);
    host_ack_c: cover property (cap1_stat.fall_seen ##[1:8] ce && g_side[1].ack_wr);
    frame_event_c: cover property (
        ce && frame_start ##[1:20] ce && buffer_channel_manager_event);

endmodule
`default_nettype wire

// ===== testbench/lts_reader_model.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// Register reader standing for one party on the far side of the block.
// =============================================================================
module lts_reader_model (
    input wire logic clk_sys, // System clock.
    output var lts_pkg::lts_bus_req_t req, // Request to the block.
    input wire lts_pkg::lts_bus_rsp_t rsp // Answer of the block.
);
    import lts_pkg::*;
    initial req = '0;
    // One access, held over one taken edge; the read answer stands for one cycle after
    // that edge, so it is taken at the next falling edge, before the request drops.
    // A write carries no value, so the acknowledge write is always a zero write.
    task automatic acc(input logic wr, input logic [11:0] a, output logic [31:0] d);
        @(negedge clk_sys);
        req <= '{1'b1, wr, a};
        @(negedge clk_sys);
        d = rsp.valid ? rsp.data : 32'hxxxx_xxxx;
        req <= '0;
    endtask
endmodule
`default_nettype wire

// ===== testbench/test_latch_timestamp_capture.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// Self-checking bench of the capture unit.
// =============================================================================
module test_latch_timestamp_capture;
    import lts_pkg::*;
    localparam logic [63:0] INC = 64'h0000_0100_0000_0001; // Time step per cycle.
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] pins = 2'b00; // Both capture pins.
    logic [63:0] sys_time = '0;
    logic [31:0] local_time = 32'h1000_0000;
    logic frame_start = 1'b0;
    logic ev = 1'b0; // Network-side buffer event.
    logic ack_en = 1'b0;
    logic ce = 1'b1; // Clock enable of the block.
    lts_cap_cfg_t cfg [2] = '{default: '0};
    lts_bus_req_t net_req;
    lts_bus_req_t host_req;
    lts_bus_rsp_t net_rsp;
    lts_bus_rsp_t host_rsp;
    lts_cap_stat_t stat [2];
    int fails = 0;
    int check_count = 0;
    // Clock and the two running times, which change at the falling edge.
    always #10 clk_sys = ~clk_sys;
    always @(negedge clk_sys) sys_time <= sys_time + INC;
    always @(negedge clk_sys) local_time <= local_time + 32'h0000_0001;
    lts_capture_top lts_capture_top_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .capture_input_zero(pins[0]), .capture_input_one(pins[1]), .sys_time(sys_time),
        .local_time(local_time), .frame_start(frame_start),
        .buffer_channel_manager_event(ev), .cap0_cfg(cfg[0]), .cap1_cfg(cfg[1]),
        .host_wr_ack_en(ack_en), .net_req(net_req), .net_rsp(net_rsp),
        .host_req(host_req), .host_rsp(host_rsp), .cap0_stat(stat[0]),
        .cap1_stat(stat[1]));
    lts_reader_model net_model (.clk_sys(clk_sys), .req(net_req), .rsp(net_rsp));
    lts_reader_model host_model (.clk_sys(clk_sys), .req(host_req), .rsp(host_rsp));
    // Comparison, reading and pin helpers.
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input bit h, input logic [11:0] a, output logic [31:0] d);
        if (h) host_model.acc(1'b0, a, d);
        else net_model.acc(1'b0, a, d);
    endtask
    task automatic wr(input bit h, input logic [11:0] a);
        logic [31:0] d;
        if (h) host_model.acc(1'b1, a, d);
        else net_model.acc(1'b1, a, d);
    endtask
    task automatic ts(input bit h, input logic [11:0] a, output logic [63:0] v);
        rd(h, a, v[31:0]);
        rd(h, a + LTS_HI_WORD_OFS, v[63:32]);
    endtask
    // The pin passes two flops; the time of the third edge after the change is kept.
    task automatic pin(input int i, input logic v, output logic [63:0] t);
        @(negedge clk_sys);
        pins[i] = v;
        t = sys_time + 3 * INC;
        repeat (6) @(negedge clk_sys);
    endtask
    // Continuous capture of all four edges, read by both sides.
    task automatic t_cont();
        logic [63:0] t;
        logic [63:0] v;
        for (int i = 0; i < 2; i++)
        begin
            pin(i, 1'b1, t);
            ts(1'b0, i ? LTS_L1_RISE_OFS : LTS_L0_RISE_OFS, v);
            chk("rise time", v, t);
            chk("level high", stat[i], 3'b100);
            pin(i, 1'b0, t);
            ts(1'b1, i ? LTS_L1_FALL_OFS : LTS_L0_FALL_OFS, v);
            chk("fall time", v, t);
        end
    endtask
    // Each side keeps its own frozen upper bits; a new edge overwrites.
    task automatic t_freeze();
        logic [63:0] old;
        logic [63:0] t;
        logic [63:0] v;
        ts(1'b0, LTS_L0_FALL_OFS, old);
        pin(0, 1'b1, t);
        pin(0, 1'b0, t);
        ts(1'b1, LTS_L0_FALL_OFS, v);
        chk("host fresh", v, t);
        rd(1'b0, LTS_L0_FALL_OFS + LTS_HI_WORD_OFS, v[31:0]);
        chk("net frozen", v[31:0], old[63:32]);
    endtask
    // Single event flags, cleared by the owning side only.
    task automatic t_single();
        logic [63:0] t;
        logic [63:0] x;
        logic [63:0] v;
        cfg[0] = '{1'b0, 2'b11};
        cfg[1] = '{1'b1, 2'b11};
        pin(0, 1'b1, t);
        chk("rise flag", stat[0], 3'b101);
        pin(0, 1'b0, x);
        pin(0, 1'b1, x);
        ts(1'b1, LTS_L0_RISE_OFS, v);
        chk("first kept", v, t);
        chk("host no clear", stat[0], 3'b111);
        ts(1'b0, LTS_L0_RISE_OFS, v);
        chk("net clear rise", stat[0], 3'b110);
        ts(1'b0, LTS_L0_FALL_OFS, v);
        chk("net clear fall", stat[0], 3'b100);
        pin(1, 1'b1, t);
        wr(1'b0, LTS_L1_RISE_OFS);
        wr(1'b1, LTS_L1_RISE_OFS);
        ts(1'b0, LTS_L1_RISE_OFS, v);
        chk("writes ignored", v, t);
        chk("flag kept", stat[1], 3'b101);
        ts(1'b1, LTS_L1_RISE_OFS, v);
        chk("host read clear", stat[1], 3'b100);
        pin(1, 1'b0, t);
        ack_en = 1'b1;
        ts(1'b1, LTS_L1_FALL_OFS, v);
        chk("read kept flag", stat[1], 3'b010);
        wr(1'b1, LTS_L1_FALL_OFS + LTS_HI_WORD_OFS);
        chk("ack write clear", stat[1], 3'b000);
    endtask
    // A low clock enable freezes the pin pipeline; the edge is taken once it returns.
    task automatic t_hold();
        logic [63:0] t;
        logic [63:0] v;
        ce = 1'b0;
        pin(0, 1'b0, t);
        chk("frozen level", stat[0], 3'b100);
        ce = 1'b1;
        t = sys_time + 3 * INC;
        repeat (6) @(negedge clk_sys);
        ts(1'b1, LTS_L0_FALL_OFS, v);
        chk("late fall time", v, t);
        chk("late fall flag", stat[0], 3'b010);
    endtask
    // Frame start time kept when a buffer event follows.
    task automatic t_frame();
        logic [31:0] e;
        logic [31:0] d;
        rd(1'b0, LTS_FRAME_OFS, d);
        chk("frame reset", d, LTS_FRAME_RESET);
        @(negedge clk_sys);
        frame_start = 1'b1;
        e = local_time + 32'h0000_0001;
        @(negedge clk_sys);
        frame_start = 1'b0;
        ev = 1'b1;
        @(negedge clk_sys);
        ev = 1'b0;
        rd(1'b1, LTS_FRAME_OFS, d);
        chk("frame time", d, e);
    endtask
    task automatic test_done();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence, then a watchdog that cuts a hang short.
    initial
    begin
        repeat (20) @(negedge clk_sys);
        nrst = 1'b1;
        t_frame();
        t_cont();
        t_freeze();
        t_single();
        t_hold();
        test_done();
    end
    initial
    begin
        #100000;
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
